// ===== lane_pll_pkg.sv
// Purpose: shared constants for the lane emphasis and link pll control bank
// Assumes: register index times four is the byte address on the bus
// Notes: one aligned 32-bit word per register, data in the low byte
package lane_pll_pkg;

    // ------------------------------------------------------------
    // register indices
    // ------------------------------------------------------------
    localparam logic [29:0] LANE5_IDX = 30'h000005C9;
    localparam logic [29:0] LANE6_IDX = 30'h000005CA;
    localparam logic [29:0] LANE7_IDX = 30'h000005CB;
    localparam logic [29:0] CAL_IDX = 30'h00001222;
    localparam logic [29:0] STARTUP_IDX = 30'h00001228;
    localparam logic [29:0] LOL_IDX = 30'h00001262;
    localparam logic [29:0] IRQ_STATUS_IDX = 30'h00001300;
    localparam logic [29:0] IRQ_ENABLE_IDX = 30'h00001301;
    localparam logic [29:0] IRQ_CLEAR_IDX = 30'h00001302;

    // ------------------------------------------------------------
    // reset values and command codes
    // ------------------------------------------------------------
    localparam logic [7:0] LANE_RESET = 8'h00;
    localparam logic [7:0] CAL_RESET = 8'h00;
    localparam logic [7:0] CAL_HOLD = 8'h04;
    localparam logic [7:0] STARTUP_RESET = 8'h0F;
    localparam logic [7:0] STARTUP_HOLD = 8'h4F;
    localparam logic [7:0] LOL_RESET = 8'h00;
    localparam logic [7:0] LOL_CLEAR = 8'h80;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ------------------------------------------------------------
    // field positions and sizes
    // ------------------------------------------------------------
    localparam int NUM_LANES = 3;
    localparam int POST_TAP_EN_BIT = 7;
    localparam int LEVEL_LSB = 4;
    localparam int LEVEL_W = 3;
    localparam int EVT_W = 2;
    localparam int EVT_LOCK_LOST = 0;
    localparam int EVT_LOCK_BACK = 1;

    typedef logic [7:0] byte_t;

endpackage

// ===== pin_sync3.sv
// Purpose: three-stage synchroniser for an asynchronous level
// Assumes: input is a slow level from outside the hclk domain
// Notes: output moves only once stages two and three agree
`timescale 1ns/1ns
module pin_sync3 (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic async_in,
    output logic sync_out
);
    logic s1;
    logic s2;
    logic s3;
    logic next_sync_out;

    always_comb begin
        next_sync_out = sync_out;
        if (s2 == s3) begin
            next_sync_out = s3;
        end
    end

    // s1 feeds only s2, keeping metastability off any gate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            sync_out <= next_sync_out;
        end
    end
endmodule

// ===== pll_lock_model.sv
// Purpose: stand-in for the link pll lock detector on the far side of the bank
// Assumes: the bench commands loss of lock through a plain level
// Notes: the pin moves off the clock edge, as an analog detector would
`timescale 1ns/1ns
module pll_lock_model (
    input wire logic lose,
    output logic pin
);
    initial begin
        pin = 1'b0;
    end
    // ------------------------------------------------------------
    // lock detector output
    // ------------------------------------------------------------
    // the bench moves lose 1 ns after a rising edge, so 1 ns more lands the pin on a
    // falling edge, well clear of the edge at which the sync stages sample it
    always @(lose) begin
        pin <= #1 lose;
    end
endmodule

// ===== serdes_lane_emphasis_pll_ctrl.sv
// Purpose: lane post-tap emphasis and link pll control bank on AHB-Lite
// Assumes: zero wait state slave, single word transfers, low byte used
// Notes: lock-lost input is asynchronous and passes a three-stage sync
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
module serdes_lane_emphasis_pll_ctrl
    import lane_pll_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic pll_lock_lost_pin,
    output logic [lane_pll_pkg::NUM_LANES-1:0] lane_post_tap_en,
    output logic [lane_pll_pkg::NUM_LANES*lane_pll_pkg::LEVEL_W-1:0] lane_post_tap_level,
    output logic pll_cal_reset,
    output logic pll_startup_reset,
    output logic pll_lock_lost_flag,
    output logic irq
);
    import lane_pll_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    byte_t lane_reg [NUM_LANES];
    byte_t cal_ctrl;
    byte_t startup_ctrl;
    byte_t lol_ctrl;
    logic [EVT_W-1:0] irq_status;
    logic [EVT_W-1:0] irq_enable;
    logic dp_write;
    logic dp_read;
    logic [29:0] dp_idx;
    logic lock_prev;

    byte_t next_lane_reg [NUM_LANES];
    byte_t next_cal_ctrl;
    byte_t next_startup_ctrl;
    byte_t next_lol_ctrl;
    logic [EVT_W-1:0] next_irq_status;
    logic [EVT_W-1:0] next_irq_enable;
    logic next_dp_write;
    logic next_dp_read;
    logic [29:0] next_dp_idx;
    logic next_lock_flag;

    logic lock_sync;
    logic lock_rise;
    logic lock_fall;
    logic addr_phase;
    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] clr_mask;
    logic [29:0] lane_idx [NUM_LANES];

    assign lane_idx[0] = LANE5_IDX;
    assign lane_idx[1] = LANE6_IDX;
    assign lane_idx[2] = LANE7_IDX;

    // ------------------------------------------------------------
    // lock-lost input
    // ------------------------------------------------------------
    pin_sync3 lock_sync_u (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pll_lock_lost_pin),
        .sync_out(lock_sync)
    );

    assign lock_rise = lock_sync && !lock_prev;
    assign lock_fall = !lock_sync && lock_prev;
    assign events = {lock_fall, lock_rise};

    // ------------------------------------------------------------
    // bus side
    // ------------------------------------------------------------
    // no wait states: every access completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addr_phase = hsel && hready && htrans[1];
    assign clr_mask = (dp_write && dp_idx == IRQ_CLEAR_IDX) ? hwdata[EVT_W-1:0] : '0;

    always_comb begin
        hrdata = 32'h00000000;
        if (dp_read) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                if (dp_idx == lane_idx[i]) begin
                    hrdata = {24'h000000, lane_reg[i]};
                end
            end
            unique case (dp_idx)
                CAL_IDX: hrdata = {24'h000000, cal_ctrl};
                STARTUP_IDX: hrdata = {24'h000000, startup_ctrl};
                LOL_IDX: hrdata = {24'h000000, lol_ctrl};
                IRQ_STATUS_IDX: hrdata = {30'h00000000, irq_status};
                IRQ_ENABLE_IDX: hrdata = {30'h00000000, irq_enable};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_lane_reg = lane_reg;
        next_cal_ctrl = cal_ctrl;
        next_startup_ctrl = startup_ctrl;
        next_lol_ctrl = lol_ctrl;
        next_irq_enable = irq_enable;
        next_dp_write = addr_phase && hwrite;
        next_dp_read = addr_phase && !hwrite;
        next_dp_idx = addr_phase ? haddr[31:2] : dp_idx;
        if (dp_write) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                if (dp_idx == lane_idx[i]) begin
                    next_lane_reg[i] = hwdata[7:0];
                end
            end
            unique case (dp_idx)
                CAL_IDX: next_cal_ctrl = hwdata[7:0];
                STARTUP_IDX: next_startup_ctrl = hwdata[7:0];
                LOL_IDX: next_lol_ctrl = hwdata[7:0];
                IRQ_ENABLE_IDX: next_irq_enable = hwdata[EVT_W-1:0];
                default: ;
            endcase
        end
        next_lock_flag = pll_lock_lost_flag;
        if (lock_rise) begin
            next_lock_flag = 1'b1;
        end else if (lol_ctrl == LOL_CLEAR) begin
            next_lock_flag = 1'b0;
        end
        // an event in the clearing cycle is kept
        next_irq_status = (irq_status & ~clr_mask) | events;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_LANES; i++) begin
                lane_reg[i] <= LANE_RESET;
            end
            cal_ctrl <= CAL_RESET;
            startup_ctrl <= STARTUP_RESET;
            lol_ctrl <= LOL_RESET;
            irq_status <= IRQ_RESET;
            irq_enable <= IRQ_RESET;
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_idx <= 30'h00000000;
            lock_prev <= 1'b0;
            pll_lock_lost_flag <= 1'b0;
        end else begin
            lane_reg <= next_lane_reg;
            cal_ctrl <= next_cal_ctrl;
            startup_ctrl <= next_startup_ctrl;
            lol_ctrl <= next_lol_ctrl;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            dp_write <= next_dp_write;
            dp_read <= next_dp_read;
            dp_idx <= next_dp_idx;
            lock_prev <= lock_sync;
            pll_lock_lost_flag <= next_lock_flag;
        end
    end

    // ------------------------------------------------------------
    // control outputs
    // ------------------------------------------------------------
    // reserved low nibble is stored but steers nothing
    genvar g;
    generate
        for (g = 0; g < NUM_LANES; g++) begin : lane_out
            assign lane_post_tap_en[g] = lane_reg[g][POST_TAP_EN_BIT];
            assign lane_post_tap_level[g*LEVEL_W +: LEVEL_W] =
                lane_reg[g][LEVEL_LSB +: LEVEL_W];
        end
    endgenerate

    assign pll_cal_reset = (cal_ctrl == CAL_HOLD);
    assign pll_startup_reset = (startup_ctrl == STARTUP_HOLD);
    assign irq = |(irq_status & irq_enable);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    lane5_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_write && dp_idx == LANE5_IDX) |=> (lane_post_tap_en[0] == $past(hwdata[7])
        && lane_post_tap_level[2:0] == $past(hwdata[6:4])))
        else $error("lane 5 emphasis fields not taken from write");
    cal_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_write && dp_idx == CAL_IDX && hwdata[7:0] == 8'h04) |=> pll_cal_reset)
        else $error("calibration reset not asserted after 0x04");
    cal_reset_val_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (cal_ctrl == 8'h00 && !pll_cal_reset))
        else $error("calibration control reset value wrong");
    startup_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_write && dp_idx == STARTUP_IDX && hwdata[7:0] == 8'h4F) |=> pll_startup_reset)
        else $error("start-up reset not asserted after 0x4F");
    startup_reset_val_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (startup_ctrl == 8'h0F && !pll_startup_reset))
        else $error("start-up control reset value wrong");
    lock_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (dp_write && dp_idx == LOL_IDX && hwdata[7:0] == 8'h80) ##1 !lock_rise
        |=> !pll_lock_lost_flag)
        else $error("lock-lost flag not cleared by 0x80");
    lock_reset_val_a: assert property (@(posedge hclk)
        $rose(hresetn) |-> (lol_ctrl == 8'h00 && !pll_lock_lost_flag))
        else $error("lock control reset value wrong");
    lock_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
        lock_rise |=> (pll_lock_lost_flag && irq_status[0]))
        else $error("lock loss not latched");
endmodule

// ===== test_serdes_lane_emphasis_pll_ctrl.sv
// Purpose: self-checking bench for the lane emphasis and link pll control bank
// Assumes: one AHB-Lite master in the bench, single slave so hready is hreadyout
// Notes: byte address is register index times four
`timescale 1ns/1ns
module test_serdes_lane_emphasis_pll_ctrl;
    import lane_pll_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, lose, pin;
    logic hreadyout, hresp, irq, cal_rst, st_rst, flag;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd_q;
    logic [NUM_LANES-1:0] en;
    logic [NUM_LANES*LEVEL_W-1:0] lvl;
    int err_count, tests_run;
    assign hready = hreadyout;
    serdes_lane_emphasis_pll_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pll_lock_lost_pin(pin), .lane_post_tap_en(en), .lane_post_tap_level(lvl),
        .pll_cal_reset(cal_rst), .pll_startup_reset(st_rst), .pll_lock_lost_flag(flag),
        .irq(irq));
    pll_lock_model model_u (.lose(lose), .pin(pin));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // read data is taken before the updates of the sampling edge land
    always @(posedge hclk) begin
        rd_q <= hrdata;
    end
    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic [29:0] idx, input logic wr, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        #1;
    endtask
    task automatic rd_chk(input string name, input logic [29:0] idx, input logic [31:0] exp);
        xfer(idx, 1'b0, 32'h0);
        chk(name, exp, rd_q);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int i = 0; i < NUM_LANES; i++) begin
            rd_chk("lane reg", LANE5_IDX + 30'(i), 32'h0);
        end
        rd_chk("cal reg", CAL_IDX, 32'h00);
        rd_chk("startup reg", STARTUP_IDX, 32'h0F);
        rd_chk("lock ctrl reg", LOL_IDX, 32'h00);
        rd_chk("unmapped", 30'h00000100, 32'h0);
        chk("cal out", 32'h0, 32'(cal_rst));
        chk("startup out", 32'h0, 32'(st_rst));
        chk("lock flag", 32'h0, 32'(flag));
        chk("response", 32'h0, 32'(hresp));
        chk("ready out", 32'h1, 32'(hreadyout));
        $display("test reset values done");
    endtask
    task automatic t_lanes;
        logic [7:0] v;
        for (int i = 0; i < NUM_LANES; i++) begin
            for (int c = 0; c <= 4; c++) begin
                v = {1'(c + i), 3'(c), 4'h0};
                xfer(LANE5_IDX + 30'(i), 1'b1, {24'h0, v});
                chk("lane enable", 32'(v[7]), 32'(en[i]));
                chk("lane level", 32'(v[6:4]), 32'(lvl[i*3 +: 3]));
                rd_chk("lane readback", LANE5_IDX + 30'(i), {24'h0, v});
            end
        end
        chk("all enables", 32'h2, 32'(en));
        chk("all levels", 32'h124, 32'(lvl));
        $display("test lane emphasis done");
    endtask
    task automatic t_pll;
        xfer(CAL_IDX, 1'b1, 32'h04);
        chk("cal reset", 32'h1, 32'(cal_rst));
        chk("startup idle", 32'h0, 32'(st_rst));
        xfer(STARTUP_IDX, 1'b1, 32'h4F);
        chk("startup reset", 32'h1, 32'(st_rst));
        xfer(CAL_IDX, 1'b1, 32'h00);
        chk("cal release", 32'h0, 32'(cal_rst));
        rd_chk("startup held", STARTUP_IDX, 32'h4F);
        // a second reset in mid-run must restore the normal values
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        #1;
        chk("startup after reset", 32'h0, 32'(st_rst));
        chk("levels after reset", 32'h0, 32'(lvl));
        rd_chk("startup reg again", STARTUP_IDX, 32'h0F);
        $display("test pll control done");
    endtask
    task automatic wait_flag(input logic exp);
        for (int n = 0; n < 20 && flag !== exp; n++) begin
            @(posedge hclk);
        end
        #1;
    endtask
    task automatic t_lock;
        xfer(IRQ_ENABLE_IDX, 1'b1, 32'h1);
        rd_chk("irq enable", IRQ_ENABLE_IDX, 32'h1);
        rd_chk("clear reads zero", IRQ_CLEAR_IDX, 32'h0);
        lose <= 1'b1;
        wait_flag(1'b1);
        chk("flag set", 32'h1, 32'(flag));
        chk("irq on loss", 32'h1, 32'(irq));
        xfer(LOL_IDX, 1'b1, 32'h80);
        // the clear acts at the edge after the control byte first reads 0x80
        @(posedge hclk);
        #1;
        chk("flag cleared", 32'h0, 32'(flag));
        rd_chk("lock ctrl", LOL_IDX, 32'h80);
        lose <= 1'b0;
        repeat (10) @(posedge hclk);
        rd_chk("status both", IRQ_STATUS_IDX, 32'h3);
        xfer(IRQ_ENABLE_IDX, 1'b1, 32'h0);
        chk("irq masked", 32'h0, 32'(irq));
        xfer(IRQ_CLEAR_IDX, 1'b1, 32'h3);
        rd_chk("status clear", IRQ_STATUS_IDX, 32'h0);
        xfer(LOL_IDX, 1'b1, 32'h00);
        lose <= 1'b1;
        wait_flag(1'b1);
        chk("flag sets again", 32'h1, 32'(flag));
        $display("test lock flag done");
    endtask
    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        lose = 1'b0;
        err_count = 0;
        tests_run = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_lanes;
        t_pll;
        t_lock;
        results;
    end
    // the tests need well under a thousand cycles; four thousand means a hang
    initial begin
        repeat (4000) @(posedge hclk);
        err_count++;
        results;
    end
endmodule
